// ==== lcdrd_map.svh ====
// What this block does
// - read frame: start, id, addr, restart, id, data, stop
// - ids 0111000 control, 0111001 segment memory
// - first direction bit is low, write
// - slave acknowledges both ids and address byte
// - master sends 8-bit start address after ack
// - repeated start, then same slave id again
// - second direction bit is high, read
// - slave drives data bytes on clocks 1-8
// - master acks 8th to 9th falling edge
// - slave address advances by one per byte
// - last byte not acked, then stop
// - bad frame or unknown id ends with stop
// - stuck data line: pull display reset low
`ifndef LCDRD_MAP_SVH
`define LCDRD_MAP_SVH

// seven-bit slave ids of the two blocks
`define LCDRD_ID_CTL 7'h38
`define LCDRD_ID_SEG 7'h39
// direction bit values
`define LCDRD_DIR_WR 1'b0
`define LCDRD_DIR_RD 1'b1
// bits per byte before the acknowledge slot
`define LCDRD_BYTE_BITS 4'h8
`define LCDRD_LAST_DATA_BIT 4'h7
// bus clock period and system clock period, in ns
`define LCDRD_SCL_PERIOD_NS 10000
`define LCDRD_CLK_PERIOD_NS 20
// quarter of a bus clock in system cycles, rounded down
`define LCDRD_QTR_CYC ((`LCDRD_SCL_PERIOD_NS / `LCDRD_CLK_PERIOD_NS) / 4)
// quarters of low data line in idle before recovery, less one
`define LCDRD_STUCK_QTRS 8'h24
// quarters the display reset is held low, less one
`define LCDRD_RST_QTRS 8'h08
// receive buffer depth
`define LCDRD_FIFO_DEPTH 32

`endif

// ==== lcdrd_pkg.sv ====
package lcdrd_pkg;

    // device end states
    typedef enum logic [2:0] {
        DEV_IDLE, DEV_ID, DEV_ADDR, DEV_ACK, DEV_TX, DEV_MACK, DEV_IGN
    } lcdrd_dev_st_t;

    // master end states
    typedef enum logic [2:0] {
        HST_IDLE, HST_STA, HST_BYTE, HST_STO, HST_RCV
    } lcdrd_hst_st_t;

    // which byte of the frame the master is on
    typedef enum logic [1:0] {
        PH_ID_W, PH_ADDR, PH_ID_R, PH_DATA
    } lcdrd_phase_t;

    typedef struct packed {
        lcdrd_dev_st_t st;
        lcdrd_dev_st_t after; // state taken when the ack slot ends
        logic [2:0] s1;       // sync stage one: reset, scl, sda
        logic [2:0] s2;       // sync stage two
        logic scl_q;
        logic sda_q;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] addr;
        logic seg;
        logic sda_oe;
        logic mack;
    } lcdrd_dev_s_t;

    typedef struct packed {
        lcdrd_hst_st_t st;
        lcdrd_phase_t ph;
        logic [1:0] step;
        logic [15:0] qcnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] rxb;
        logic [7:0] cnt;
        logic seg;
        logic [7:0] addr;
        logic ackb;
        logic scl;
        logic sda_oe;
        logic rst_n;
        logic [7:0] low;
        logic push;
        logic busy;
        logic err;
        logic cmd_rdy;
        logic s1;
        logic s2;
    } lcdrd_hst_s_t;

endpackage

// ==== lcdrd_bus_if.sv ====
`timescale 1ns/1ps
interface lcdrd_bus_if;
    logic scl_o; // bus clock, driven by the master only
    logic sda_m_o; // master data out, held low
    logic sda_m_oe; // master pulls data low
    logic sda_s_o; // slave data out, held low
    logic sda_s_oe; // slave pulls data low
    logic display_reset_port_bit_n; // display controller reset
    logic scl; // resolved clock line
    logic sda; // resolved open-drain data line, pulled up

    assign scl = scl_o;
    // wired-and of both open-drain drivers
    assign sda = !((sda_m_oe & !sda_m_o) | (sda_s_oe & !sda_s_o));

    modport host (
        output scl_o,
        output sda_m_o,
        output sda_m_oe,
        output display_reset_port_bit_n,
        input sda
    );
    modport dev (
        output sda_s_o,
        output sda_s_oe,
        input scl,
        input sda,
        input display_reset_port_bit_n
    );
endinterface

// ==== lcdrd_fifo.sv ====
`timescale 1ns/1ps
module lcdrd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp; // extra bit tells full from empty
        logic [AW:0] rp;
        logic full;
        logic empty;
    } lcdrd_fifo_s_t;

    lcdrd_fifo_s_t r_ff;
    lcdrd_fifo_s_t nxt_r;

    // flags are registered so in_ready and out_valid come from flops
    assign in_ready = !r_ff.full;
    assign out_valid = !r_ff.empty;
    assign out_data = r_ff.mem[r_ff.rp[AW-1:0]];

    // pointer update, write refused while full
    always_comb begin
        nxt_r = r_ff;
        if (in_valid && !r_ff.full) begin
            nxt_r.mem[r_ff.wp[AW-1:0]] = in_data;
            nxt_r.wp = r_ff.wp + 1'b1;
        end
        if (out_ready && !r_ff.empty) begin
            nxt_r.rp = r_ff.rp + 1'b1;
        end
        nxt_r.empty = (nxt_r.wp == nxt_r.rp);
        nxt_r.full = (nxt_r.wp[AW] != nxt_r.rp[AW]) && (nxt_r.wp[AW-1:0] == nxt_r.rp[AW-1:0]);
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= '0;
            r_ff.empty <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// ==== lcdrd_dev.sv ====
`timescale 1ns/1ps
`include "lcdrd_map.svh"
module lcdrd_dev (
    lcdrd_bus_if.dev bus,
    input wire logic clk_sys,
    input wire logic reset_n,
    output logic rd_seg,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    lcdrd_pkg::lcdrd_dev_s_t r_ff; // whole device state
    lcdrd_pkg::lcdrd_dev_s_t nxt_r;
    logic scl; // synchronised clock line
    logic sda; // synchronised data line
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign scl = r_ff.s2[1];
    assign sda = r_ff.s2[0];
    assign rise = scl && !r_ff.scl_q;
    assign fall = !scl && r_ff.scl_q;
    // data moving while clock high marks start and stop
    assign start = scl && r_ff.scl_q && r_ff.sda_q && !sda;
    assign stop = scl && r_ff.scl_q && !r_ff.sda_q && sda;

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = r_ff.sda_oe;
    assign rd_seg = r_ff.seg;
    assign rd_addr = r_ff.addr;

    // frame decoder; except at display reset, data changes only after a falling clock edge
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = {bus.display_reset_port_bit_n, bus.scl, bus.sda};
        nxt_r.s2 = r_ff.s1;
        nxt_r.scl_q = scl;
        nxt_r.sda_q = sda;
        if (!r_ff.s2[2]) begin
            // display reset frees a stuck data line
            nxt_r.st = lcdrd_pkg::DEV_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else if (start) begin
            // start and restart both begin a new id byte; address is kept
            nxt_r.st = lcdrd_pkg::DEV_ID;
            nxt_r.bitn = '0;
            nxt_r.sda_oe = 1'b0;
        end else if (stop) begin
            nxt_r.st = lcdrd_pkg::DEV_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else begin
            case (r_ff.st)
                lcdrd_pkg::DEV_ID, lcdrd_pkg::DEV_ADDR: begin
                    if (rise) begin
                        // shift in, first bit lands highest
                        nxt_r.sh = {r_ff.sh[6:0], sda};
                        nxt_r.bitn = r_ff.bitn + 1'b1;
                    end else if (fall && r_ff.bitn == `LCDRD_BYTE_BITS) begin
                        nxt_r.bitn = '0;
                        if (r_ff.st == lcdrd_pkg::DEV_ADDR) begin
                            nxt_r.addr = r_ff.sh;
                            nxt_r.sda_oe = 1'b1;
                            // write data is not handled here; wait for restart
                            nxt_r.after = lcdrd_pkg::DEV_IGN;
                            nxt_r.st = lcdrd_pkg::DEV_ACK;
                        end else if (r_ff.sh[7:1] == `LCDRD_ID_CTL || r_ff.sh[7:1] == `LCDRD_ID_SEG) begin
                            nxt_r.seg = (r_ff.sh[7:1] == `LCDRD_ID_SEG);
                            nxt_r.sda_oe = 1'b1;
                            nxt_r.after = (r_ff.sh[0] == `LCDRD_DIR_RD) ? lcdrd_pkg::DEV_TX : lcdrd_pkg::DEV_ADDR;
                            nxt_r.st = lcdrd_pkg::DEV_ACK;
                        end else begin
                            // foreign id: stay off the line until next start
                            nxt_r.st = lcdrd_pkg::DEV_IGN;
                        end
                    end
                end
                lcdrd_pkg::DEV_ACK: begin
                    // ack held through the ninth clock, dropped at its fall
                    if (fall) begin
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.st = r_ff.after;
                        if (r_ff.after == lcdrd_pkg::DEV_TX) begin
                            nxt_r.sh = rd_data;
                            nxt_r.sda_oe = !rd_data[7];
                        end
                    end
                end
                lcdrd_pkg::DEV_TX: begin
                    if (rise) begin
                        nxt_r.bitn = r_ff.bitn + 1'b1;
                    end else if (fall) begin
                        if (r_ff.bitn == `LCDRD_BYTE_BITS) begin
                            // release for the master's ack, step to next register
                            nxt_r.sda_oe = 1'b0;
                            nxt_r.addr = r_ff.addr + 8'h01;
                            nxt_r.st = lcdrd_pkg::DEV_MACK;
                        end else begin
                            nxt_r.sda_oe = !r_ff.sh[6];
                            nxt_r.sh = {r_ff.sh[6:0], 1'b0};
                        end
                    end
                end
                lcdrd_pkg::DEV_MACK: begin
                    if (rise) begin
                        nxt_r.mack = sda;
                    end else if (fall) begin
                        nxt_r.bitn = '0;
                        if (!r_ff.mack) begin
                            // acked: next byte from the advanced address
                            nxt_r.sh = rd_data;
                            nxt_r.sda_oe = !rd_data[7];
                            nxt_r.st = lcdrd_pkg::DEV_TX;
                        end else begin
                            // no ack: last byte, wait for stop
                            nxt_r.st = lcdrd_pkg::DEV_IGN;
                        end
                    end
                end
                default: begin
                    nxt_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // state register; sync stages reset to idle-high lines
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= '0;
            r_ff.s1 <= 3'h7;
            r_ff.s2 <= 3'h7;
            r_ff.scl_q <= 1'b1;
            r_ff.sda_q <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// ==== lcdrd_host.sv ====
`timescale 1ns/1ps
`include "lcdrd_map.svh"
module lcdrd_host #(
    parameter int QTR = `LCDRD_QTR_CYC, // system cycles per quarter bus clock
    parameter int DEPTH = `LCDRD_FIFO_DEPTH // receive buffer words
) (
    lcdrd_bus_if.host bus,
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_seg,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_count,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic busy,
    output logic nak_err
);
    lcdrd_pkg::lcdrd_hst_s_t r_ff; // whole master state
    lcdrd_pkg::lcdrd_hst_s_t nxt_r;
    logic tick; // one quarter of a bus clock has passed
    logic sda; // synchronised data line
    logic fifo_in_ready; // room for one more received byte
    logic is_data; // current byte is read data

    assign tick = (r_ff.qcnt == 16'(QTR - 1));
    assign sda = r_ff.s2;
    assign is_data = (r_ff.ph == lcdrd_pkg::PH_DATA);

    assign bus.scl_o = r_ff.scl;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = r_ff.sda_oe;
    assign bus.display_reset_port_bit_n = r_ff.rst_n;
    assign cmd_ready = r_ff.cmd_rdy;
    assign busy = r_ff.busy;
    assign nak_err = r_ff.err;

    // received bytes wait here; a full buffer stalls the bus clock
    lcdrd_fifo #(
        .W(8),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(r_ff.push),
        .in_ready(fifo_in_ready),
        .in_data(r_ff.rxb),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // frame sequencer, paced by the quarter tick
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = bus.sda;
        nxt_r.s2 = r_ff.s1;
        nxt_r.push = 1'b0;
        nxt_r.qcnt = tick ? 16'h0000 : r_ff.qcnt + 16'h0001;
        case (r_ff.st)
            lcdrd_pkg::HST_IDLE: begin
                nxt_r.scl = 1'b1;
                nxt_r.sda_oe = 1'b0;
                if (cmd_valid && r_ff.cmd_rdy) begin
                    // take the command, open with a write-direction id
                    nxt_r.seg = cmd_seg;
                    nxt_r.addr = cmd_addr;
                    // a zero count still reads one byte
                    nxt_r.cnt = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
                    nxt_r.ph = lcdrd_pkg::PH_ID_W;
                    nxt_r.sh = {cmd_seg ? `LCDRD_ID_SEG : `LCDRD_ID_CTL, `LCDRD_DIR_WR};
                    nxt_r.st = lcdrd_pkg::HST_STA;
                    nxt_r.step = 2'h0;
                    nxt_r.qcnt = 16'h0000;
                    nxt_r.busy = 1'b1;
                    nxt_r.err = 1'b0;
                    nxt_r.low = 8'h00;
                end else if (tick) begin
                    // a line low while nobody talks means a stuck slave
                    if (!sda) begin
                        nxt_r.low = r_ff.low + 8'h01;
                        if (r_ff.low == `LCDRD_STUCK_QTRS) begin
                            nxt_r.rst_n = 1'b0;
                            nxt_r.low = 8'h00;
                            nxt_r.busy = 1'b1;
                            nxt_r.st = lcdrd_pkg::HST_RCV;
                        end
                    end else begin
                        nxt_r.low = 8'h00;
                    end
                end
            end
            lcdrd_pkg::HST_RCV: begin
                // hold the display reset, then let it go
                if (tick) begin
                    nxt_r.low = r_ff.low + 8'h01;
                    if (r_ff.low == `LCDRD_RST_QTRS) begin
                        nxt_r.rst_n = 1'b1;
                        nxt_r.low = 8'h00;
                        nxt_r.busy = 1'b0;
                        nxt_r.st = lcdrd_pkg::HST_IDLE;
                    end
                end
            end
            lcdrd_pkg::HST_STA: begin
                // start or repeated start: clock low, data up, clock up, data down
                if (tick) begin
                    nxt_r.step = r_ff.step + 2'h1;
                    case (r_ff.step)
                        2'h0: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.sda_oe = 1'b0;
                        end
                        2'h1: begin
                            nxt_r.scl = 1'b1;
                        end
                        2'h2: begin
                            nxt_r.sda_oe = 1'b1;
                        end
                        default: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.bitn = 4'h0;
                            nxt_r.st = lcdrd_pkg::HST_BYTE;
                        end
                    endcase
                end
            end
            lcdrd_pkg::HST_STO: begin
                // stop: data low under low clock, clock up, data up
                if (tick) begin
                    nxt_r.step = r_ff.step + 2'h1;
                    case (r_ff.step)
                        2'h0: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.sda_oe = 1'b1;
                        end
                        2'h1: begin
                            nxt_r.scl = 1'b1;
                        end
                        2'h2: begin
                            nxt_r.sda_oe = 1'b0;
                        end
                        default: begin
                            nxt_r.busy = 1'b0;
                            nxt_r.st = lcdrd_pkg::HST_IDLE;
                        end
                    endcase
                end
            end
            lcdrd_pkg::HST_BYTE: begin
                // nine bits of four quarters: set, clock up, sample, clock down
                if (tick) begin
                    nxt_r.step = r_ff.step + 2'h1;
                    case (r_ff.step)
                        2'h0: begin
                            if (is_data && r_ff.bitn == 4'h0 && !fifo_in_ready) begin
                                // no room: keep the clock low until the reader drains
                                nxt_r.step = 2'h0;
                            end else if (r_ff.bitn < `LCDRD_BYTE_BITS) begin
                                // send msb first; release while the slave sends
                                nxt_r.sda_oe = !is_data && !r_ff.sh[7];
                            end
                        end
                        2'h1: begin
                            nxt_r.scl = 1'b1;
                        end
                        2'h2: begin
                            if (r_ff.bitn == `LCDRD_BYTE_BITS) begin
                                nxt_r.ackb = sda;
                            end else if (is_data) begin
                                nxt_r.rxb = {r_ff.rxb[6:0], sda};
                            end else begin
                                nxt_r.sh = {r_ff.sh[6:0], 1'b0};
                            end
                        end
                        default: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.bitn = r_ff.bitn + 4'h1;
                            if (r_ff.bitn == `LCDRD_LAST_DATA_BIT) begin
                                // ack from the 8th fall to the 9th; none on the last byte
                                nxt_r.sda_oe = is_data && (r_ff.cnt != 8'h01);
                            end
                            if (r_ff.bitn == `LCDRD_BYTE_BITS) begin
                                nxt_r.bitn = 4'h0;
                                if (!is_data && r_ff.ackb) begin
                                    // no ack to id or address: end the frame
                                    nxt_r.err = 1'b1;
                                    nxt_r.st = lcdrd_pkg::HST_STO;
                                end else begin
                                    case (r_ff.ph)
                                        lcdrd_pkg::PH_ID_W: begin
                                            nxt_r.ph = lcdrd_pkg::PH_ADDR;
                                            nxt_r.sh = r_ff.addr;
                                        end
                                        lcdrd_pkg::PH_ADDR: begin
                                            // same id again, now reading
                                            nxt_r.ph = lcdrd_pkg::PH_ID_R;
                                            nxt_r.sh[7:1] = r_ff.seg ? `LCDRD_ID_SEG : `LCDRD_ID_CTL;
                                            nxt_r.sh[0] = `LCDRD_DIR_RD;
                                            nxt_r.st = lcdrd_pkg::HST_STA;
                                        end
                                        lcdrd_pkg::PH_ID_R: begin
                                            nxt_r.ph = lcdrd_pkg::PH_DATA;
                                        end
                                        default: begin
                                            // room was checked before the byte began
                                            nxt_r.push = 1'b1;
                                            nxt_r.cnt = r_ff.cnt - 8'h01;
                                            if (r_ff.cnt == 8'h01) begin
                                                nxt_r.st = lcdrd_pkg::HST_STO;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                nxt_r.st = lcdrd_pkg::HST_IDLE;
            end
        endcase
        // ready only while idle with a clean line
        nxt_r.cmd_rdy = (nxt_r.st == lcdrd_pkg::HST_IDLE) && (nxt_r.low == 8'h00) && !(cmd_valid && r_ff.cmd_rdy);
    end

    // state register; lines idle high, display reset released
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= '0;
            r_ff.scl <= 1'b1;
            r_ff.rst_n <= 1'b1;
            r_ff.s1 <= 1'b1;
            r_ff.s2 <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// ==== lcdrd_chk.sv ====
`timescale 1ns/1ps
module lcdrd_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe,
    input wire logic display_reset_port_bit_n
);
    logic scl_ff, sda_ff, rs_ff, fr_ff; // wire history, restart seen, inside frame
    logic [7:0] sh_ff, cnt_ff; // bits and rises since the last start
    wire st = scl && scl_ff && sda_ff && !sda;
    wire up = scl && !scl_ff;
    // follow the wire; a start inside a frame is a restart
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {scl_ff, sda_ff, rs_ff, fr_ff, sh_ff, cnt_ff} <= '0;
        end else begin
            scl_ff <= scl;
            sda_ff <= sda;
            if (st) begin
                rs_ff <= fr_ff;
                fr_ff <= 1'b1;
                cnt_ff <= 8'h00;
            end else if (up) begin
                sh_ff <= {sh_ff[6:0], sda};
                // saturate so long reads never wrap back onto the id counts
                if (cnt_ff != 8'hFF) cnt_ff <= cnt_ff + 8'h01;
            end
            if (scl && scl_ff && !sda_ff && sda) fr_ff <= 1'b0;
        end
    end
    id_dir_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        up && cnt_ff == 8'h07 |-> sh_ff[6:1] == 6'h1C && sda == rs_ff) else $error("bad id or direction");
    id_ack_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        up && cnt_ff == 8'h08 |-> !sda && sda_s_oe) else $error("id not acknowledged");
    // 18 bit clocks, plus the restart's own clock rise before data falls
    restart_pos_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        st && fr_ff |-> cnt_ff == 8'h13) else $error("restart misplaced");
    slave_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n || !display_reset_port_bit_n)
        scl && scl_ff |-> $stable(sda_s_oe)) else $error("slave moved data with clock high");
    scl_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(scl) |=> scl[*3]) else $error("clock high too short");
    rst_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(display_reset_port_bit_n) |=> !display_reset_port_bit_n[*8] ##[20:40] display_reset_port_bit_n)
        else $error("display reset length");
    rst_scl_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !display_reset_port_bit_n |-> scl) else $error("clock moved in recovery");
    rst_rel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(display_reset_port_bit_n) |-> ##6 !sda_s_oe) else $error("slave kept line in reset");
endmodule

// ==== lcdrd_bench.sv ====
`timescale 1ns/1ps
module lcdrd_bench;
    logic clk_sys = 0, reset_n = 0, hrst_n = 1, drst_n = 1, cmd_valid = 0, cmd_seg = 0, rx_ready = 0, hold = 0;
    logic [7:0] cmd_addr = 8'h00, cmd_count = 8'h00, rx_data, rd_addr, rd_data, mem [512];
    logic cmd_ready, rx_valid, busy, rd_seg, nak_err;
    logic [7:0] exp_q [$]; // expected words in arrival order
    int n_mismatch = 0, checks_done = 0;
    logic [31:0] rng = 32'h00000F65;
    lcdrd_bus_if bus();
    // host reset is split so a frame can be cut with the slave still holding the line
    lcdrd_host #(.QTR(4), .DEPTH(32)) lcdrd_host_inst (.bus(bus), .clk_sys(clk_sys), .reset_n(reset_n & hrst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_seg(cmd_seg), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy), .nak_err(nak_err));
    lcdrd_dev lcdrd_dev_inst (.bus(bus), .clk_sys(clk_sys), .reset_n(reset_n & drst_n), .rd_seg(rd_seg),
        .rd_addr(rd_addr), .rd_data(rd_data));
    lcdrd_chk lcdrd_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n & hrst_n & drst_n), .scl(bus.scl), .sda(bus.sda),
        .sda_s_oe(bus.sda_s_oe), .display_reset_port_bit_n(bus.display_reset_port_bit_n));
    assign rd_data = mem[{rd_seg, rd_addr}]; // register file behind the device
    always #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // random stalls on the receive side
    always @(negedge clk_sys) begin
        rng = xs(rng);
        rx_ready <= !hold && rng[0];
    end
    // each word taken is matched to the oldest note
    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) cmp(rx_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
    task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] n, input bit p);
        int i;
        @(negedge clk_sys);
        {cmd_seg, cmd_addr, cmd_count, cmd_valid} = {s, a, n, 1'b1};
        for (i = 0; i < 99 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 0;
        for (i = 0; p && i < (n ? n : 1); i++) exp_q.push_back(mem[{s, a + i[7:0]}]);
    endtask
    task automatic idle(input int lim);
        int i;
        for (i = 0; i < lim && (busy !== 1'b0 || exp_q.size()); i++) @(negedge clk_sys);
        cmp(busy, 0);
        cmp(8'(exp_q.size()), 0);
    endtask
    task automatic run(input logic s, input logic [7:0] a, input logic [7:0] n);
        rd(s, a, n, 1);
        idle(9000);
        cmp(nak_err, 0);
        $display("read done block %0d addr %h count %0d", s, a, n);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        int i;
        for (i = 0; i < 512; i++) begin
            rng = xs(rng);
            mem[i] = rng[7:0];
        end
        repeat (10) @(negedge clk_sys);
        reset_n = 1;
        run(1'b0, 8'hFE, 8'h03);
        run(1'b1, rng[7:0], 8'h01);
        run(1'b1, 8'h80, 8'h00);
        // full buffer must stall the bus, not drop words
        hold = 1;
        rd(1'b1, 8'h20, 8'h28, 1);
        repeat (6000) @(negedge clk_sys);
        cmp(busy, 1);
        hold = 0;
        idle(20000);
        $display("buffer stall done");
        // cut the host while the slave holds the line low
        rd(1'b0, 8'h10, 8'h01, 0);
        for (i = 0; i < 999 && bus.sda_s_oe !== 1'b1; i++) @(negedge clk_sys);
        hrst_n = 0;
        @(negedge clk_sys);
        hrst_n = 1;
        for (i = 0; i < 400 && bus.display_reset_port_bit_n !== 1'b0; i++) @(negedge clk_sys);
        cmp(busy, 1);
        idle(400);
        cmp(bus.sda, 1);
        // device held in reset never acks: master must flag it and stop
        drst_n = 0;
        rd(1'b1, 8'h00, 8'h01, 0);
        idle(2000);
        cmp(nak_err, 1);
        drst_n = 1;
        $display("recovery and refusal done");
        run(1'b0, 8'h10, 8'h02);
        complete_run;
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        complete_run;
    end
endmodule
